// *** core/fpd_consts.vh ***
/*
 * constants for the boot configuration word 0 loader: field positions,
 * encodings, register offsets and bus answers.
 * assumes it is included by bare name from files under core/.
 */
`ifndef FPD_CONSTS_VH
`define FPD_CONSTS_VH

// ----------------------------------------------------------------
// configuration word field layout
// ----------------------------------------------------------------
`define FPD_WP_HI         18
`define FPD_WP_LO         10
`define FPD_WP_TOP_LO     17
`define FPD_CH_HI         4
`define FPD_CH_LO         3
`define FPD_SCAN_BIT      2
`define FPD_DBG_HI        1
`define FPD_DBG_LO        0
`define FPD_WP_OFF        9'h1ff
`define FPD_WP_ALL        9'h000
`define FPD_DBG_FORCED    2'h3
`define FPD_KB_SHIFT      10

// ----------------------------------------------------------------
// word-aligned byte offsets of the registers
// ----------------------------------------------------------------
`define FPD_ADDR_W        4
`define FPD_OFS_CFGWORD   4'h0
`define FPD_OFS_CTRL      4'h4
`define FPD_OFS_LIMIT     4'h8
`define FPD_OFS_STATUS    4'hc
`define FPD_CTRL_SCAN_BIT 0
`define FPD_UNMAPPED_DATA 32'h0000_0000

`endif

// *** core/fpd_wp_decode.v ***
/*
 * decodes the write-protect boundary code into a byte limit.
 * assumes a registered code at its input; pure combinational logic.
 */
`timescale 1ns/1ps
`include "fpd_consts.vh"

module fpd_wp_decode #(
	parameter FLASH_BYTES = 32'h0004_0000 // implemented program flash size
) (
	// code in
	input  wire [8:0]  wp_code_in,
	// decoded boundary
	output reg  [31:0] wp_limit_out,
	output reg         wp_all_out
);
	// number of one kilobyte steps below the all ones code
	reg [8:0]  steps;
	reg [31:0] raw;

	// ----------------------------------------------------------------
	// boundary arithmetic
	// ----------------------------------------------------------------
	always @* begin
		steps        = ~wp_code_in;
		raw          = {23'h0, steps} << `FPD_KB_SHIFT;
		wp_all_out   = (wp_code_in == `FPD_WP_ALL);
		if (wp_all_out) begin
			// all possible memory is locked
			wp_limit_out = FLASH_BYTES;
		end else if (raw > FLASH_BYTES) begin
			// codes past the part's size clamp to the whole array
			wp_limit_out = FLASH_BYTES;
		end else begin
			wp_limit_out = raw;
		end
	end
endmodule // fpd_wp_decode

// *** core/fpd_cfg_loader.v ***
/*
 * boot configuration word 0 loader: samples the nonvolatile word while
 * reset is held, decodes protect boundary, debug channel, scan and
 * debugger enables, and offers them over an avalon-mm slave.
 * assumes nvm_word_in is stable during reset and code_protect_in comes
 * from the same clock domain (other configuration logic).
 */
`timescale 1ns/1ps
`include "fpd_consts.vh"

module fpd_cfg_loader #(
	parameter        HAS_256K    = 1'b1,          // part carries 256 kilobyte flash
	parameter [31:0] FLASH_BYTES = 32'h0004_0000  // implemented flash size in bytes
) (
	// clock and reset
	input  wire        clk_in,
	input  wire        sys_rst_in,
	// nonvolatile configuration source
	input  wire [31:0] nvm_word_in,
	input  wire        code_protect_in,
	// avalon-mm slave
	input  wire [3:0]  avs_address_in,
	input  wire        avs_read_in,
	input  wire        avs_write_in,
	input  wire [31:0] avs_writedata_in,
	input  wire [3:0]  avs_byteenable_in,
	output reg  [31:0] avs_readdata_out,
	output reg         avs_waitrequest_out,
	// decoded configuration
	output reg  [31:0] wp_limit_out,
	output reg         wp_enable_out,
	output reg  [3:0]  debug_pair_sel_out,
	output reg         scan_port_en_out,
	output reg         debugger_en_out
);
	// captured configuration
	reg [31:0] cfg_word_ff;       // word as sampled, forced fields applied
	reg        scan_ctrl_ff;      // control register scan enable
	reg        loaded_ff;         // a load has happened
	reg        rd_done_ff;        // answer phase of a read
	reg        wr_done_ff;        // answer phase of a write
	// next values
	reg [31:0] nxt_cfg_word;
	reg [8:0]  nxt_wp;
	reg [31:0] nxt_rdata;
	// decoder wires
	wire [31:0] dec_limit;
	wire        dec_all;
	wire [8:0]  wp_code;

	assign wp_code = cfg_word_ff[`FPD_WP_HI:`FPD_WP_LO];

	// ----------------------------------------------------------------
	// boundary decoder
	// ----------------------------------------------------------------
	fpd_wp_decode #(
		.FLASH_BYTES (FLASH_BYTES)
	) u_dec (
		.wp_code_in   (wp_code),
		.wp_limit_out (dec_limit),
		.wp_all_out   (dec_all)
	);

	// ----------------------------------------------------------------
	// word sampling and field forcing
	// ----------------------------------------------------------------
	always @* begin
		nxt_cfg_word = nvm_word_in;
		nxt_wp       = nvm_word_in[`FPD_WP_HI:`FPD_WP_LO];
		// smaller parts lack the top two boundary bits; they read as ones
		if (!HAS_256K) begin
			nxt_wp[8:7] = 2'h3;
		end
		nxt_cfg_word[`FPD_WP_HI:`FPD_WP_LO] = nxt_wp;
		// code protection overrides whatever the debug field holds
		if (code_protect_in) begin
			nxt_cfg_word[`FPD_DBG_HI:`FPD_DBG_LO] = `FPD_DBG_FORCED;
		end
	end

	// the word is taken only while reset is held, so no later nvm glitch
	// can move a protect boundary under running code
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			cfg_word_ff  <= nxt_cfg_word;
			scan_ctrl_ff <= nvm_word_in[`FPD_SCAN_BIT];
			loaded_ff    <= 1'b1;
		end else begin
			// software may later clear or set the scan enable
			if (avs_write_in && !wr_done_ff && avs_byteenable_in[0] &&
			    avs_address_in == `FPD_OFS_CTRL) begin
				scan_ctrl_ff <= avs_writedata_in[`FPD_CTRL_SCAN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// decoded outputs, registered
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			wp_limit_out       <= 32'h0;
			wp_enable_out      <= 1'b0;
			debug_pair_sel_out <= 4'h0;
			scan_port_en_out   <= 1'b0;
			debugger_en_out    <= 1'b0;
		end else begin
			wp_limit_out  <= dec_limit;
			wp_enable_out <= (wp_code != `FPD_WP_OFF) || dec_all;
			// one-hot pair select; pair four needs a bonded part
			case (cfg_word_ff[`FPD_CH_HI:`FPD_CH_LO])
				2'h3:    debug_pair_sel_out <= 4'h1;
				2'h2:    debug_pair_sel_out <= 4'h2;
				2'h1:    debug_pair_sel_out <= 4'h4;
				2'h0:    debug_pair_sel_out <= 4'h8;
				default: debug_pair_sel_out <= 4'h1;
			endcase
			scan_port_en_out <= scan_ctrl_ff;
			debugger_en_out  <= ~cfg_word_ff[`FPD_DBG_HI];
		end
	end

	// ----------------------------------------------------------------
	// avalon read mux
	// ----------------------------------------------------------------
	always @* begin
		case (avs_address_in)
			`FPD_OFS_CFGWORD: nxt_rdata = cfg_word_ff;
			`FPD_OFS_CTRL:    nxt_rdata = {31'h0, scan_ctrl_ff};
			`FPD_OFS_LIMIT:   nxt_rdata = dec_limit;
			`FPD_OFS_STATUS:  nxt_rdata = {27'h0, loaded_ff, debugger_en_out,
			                               scan_port_en_out, wp_enable_out,
			                               dec_all};
			default:          nxt_rdata = `FPD_UNMAPPED_DATA;
		endcase
	end

	// ----------------------------------------------------------------
	// avalon handshake: one wait cycle, answer on the second edge
	// ----------------------------------------------------------------
	// waitrequest is registered so the port comes straight from a flop;
	// it is low exactly when either answer-phase flag is set
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			rd_done_ff          <= 1'b0;
			wr_done_ff          <= 1'b0;
			avs_readdata_out    <= 32'h0;
			avs_waitrequest_out <= 1'b1;
		end else begin
			// answer one cycle after the request is seen, then drop
			rd_done_ff <= avs_read_in && !rd_done_ff;
			wr_done_ff <= avs_write_in && !wr_done_ff;
			avs_waitrequest_out <= !((avs_read_in && !rd_done_ff) ||
			                         (avs_write_in && !wr_done_ff));
			if (avs_read_in && !rd_done_ff) begin
				avs_readdata_out <= nxt_rdata;
			end
		end
	end
endmodule // fpd_cfg_loader

// *** verif/fpd_cfg_asserts.sv ***
/* checker for the configuration loader ports.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module fpd_chk #(
	parameter        HAS_256K    = 1'b1,
	parameter [31:0] FLASH_BYTES = 32'h0004_0000
) (
	input wire        clk_in, sys_rst_in, code_protect_in,
	input wire [31:0] nvm_word_in, avs_writedata_in, avs_readdata_out, wp_limit_out,
	input wire [3:0]  avs_address_in, avs_byteenable_in, debug_pair_sel_out,
	input wire        avs_read_in, avs_write_in, avs_waitrequest_out,
	input wire        wp_enable_out, scan_port_en_out, debugger_en_out
);
	reg [31:0] w_ff; // word as last sampled under reset
	reg        cp_ff;
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			w_ff  <= nvm_word_in;
			cp_ff <= code_protect_in;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	AST_PAIR: assert property (!$past(sys_rst_in) |->
		debug_pair_sel_out == (4'h8 >> w_ff[4:3])) else $error("pair select wrong");
	AST_DBG: assert property (!$past(sys_rst_in) |->
		debugger_en_out == !(cp_ff | w_ff[1])) else $error("debugger enable wrong");
	AST_WPEN: assert property (!$past(sys_rst_in) |->
		wp_enable_out == (w_ff[18:10] != 9'h1ff)) else $error("protect enable wrong");
	AST_KB: assert property (wp_limit_out[9:0] == 10'h0 && wp_limit_out <= FLASH_BYTES)
		else $error("limit not kilobyte step");
	AST_HOLD: assert property (!$past(sys_rst_in) && !$past(sys_rst_in, 2) |->
		$stable(wp_limit_out) && $stable(debug_pair_sel_out) && $stable(debugger_en_out))
		else $error("decoded value moved");
	AST_WAIT1: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out) else $error("answer late");
	AST_PULSE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("answer too long");
	AST_CAUSE: assert property (!avs_waitrequest_out |-> $past(avs_read_in || avs_write_in))
		else $error("answer without request");
endmodule // fpd_chk
bind fpd_cfg_loader fpd_chk #(.HAS_256K(HAS_256K), .FLASH_BYTES(FLASH_BYTES)) u_chk (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .code_protect_in(code_protect_in),
	.nvm_word_in(nvm_word_in), .avs_writedata_in(avs_writedata_in),
	.avs_readdata_out(avs_readdata_out), .wp_limit_out(wp_limit_out),
	.avs_address_in(avs_address_in), .avs_byteenable_in(avs_byteenable_in),
	.debug_pair_sel_out(debug_pair_sel_out), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
	.wp_enable_out(wp_enable_out), .scan_port_en_out(scan_port_en_out),
	.debugger_en_out(debugger_en_out));

// *** verif/fpd_nvm_model.sv ***
/* far side: nonvolatile configuration source.
   assumes load is called just after a rising clock edge. */
`timescale 1ns/1ps
module fpd_nvm_model (
	output reg [31:0] nvm_word_out     = 32'hffff_ffff,
	output reg        code_protect_out = 1'b0
);
	// reserved bits 9..5 programmed as ones; pair four is bonded here
	task load(input [31:0] w, input cp);
		begin
			nvm_word_out     <= w | 32'h0000_03e0;
			code_protect_out <= cp;
		end
	endtask
endmodule // fpd_nvm_model

// *** verif/fpd_tb.sv ***
/* self-checking bench for the configuration loader.
   assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
module tb;
	localparam [31:0] FB = 32'h0004_0000;
	localparam [53:0] CS = {9'h1f7, 9'h000, 9'h0ff, 9'h1bf, 9'h1fe, 9'h1ff};
	reg         clk_in = 1'b0, sys_rst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
	reg  [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'hf;
	reg  [31:0] avs_writedata_in = 32'h0;
	wire [31:0] nvm_w, avs_readdata_out, wp_limit_out;
	wire [3:0]  debug_pair_sel_out;
	wire        nvm_cp, avs_waitrequest_out, wp_enable_out, scan_port_en_out, debugger_en_out;
	integer     errors = 0, n_checks = 0;
	always #20 clk_in = ~clk_in;
	fpd_nvm_model nvm (.nvm_word_out(nvm_w), .code_protect_out(nvm_cp));
	fpd_cfg_loader #(.HAS_256K(1'b1), .FLASH_BYTES(FB)) dut (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .nvm_word_in(nvm_w), .code_protect_in(nvm_cp),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .wp_limit_out(wp_limit_out),
		.wp_enable_out(wp_enable_out), .debug_pair_sel_out(debug_pair_sel_out),
		.scan_port_en_out(scan_port_en_out), .debugger_en_out(debugger_en_out));
	task finish_test;
		begin
			if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
			else $display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// request held until the rising edge that sees waitrequest low
	task bus(input w, input [3:0] a, input [31:0] d, input [3:0] be, output [31:0] q);
		begin
			@(posedge clk_in);
			avs_address_in <= a; avs_writedata_in <= d; avs_byteenable_in <= be;
			avs_read_in <= !w; avs_write_in <= w;
			@(posedge clk_in);
			while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
			q = avs_readdata_out;
			avs_read_in <= 1'b0; avs_write_in <= 1'b0;
		end
	endtask
	// reset for 12 cycles, then alter the source to prove it is ignored
	task boot(input [31:0] w, input cp);
		begin
			@(posedge clk_in);
			sys_rst_in <= 1'b1;
			nvm.load(w, cp);
			repeat (12) @(posedge clk_in);
			sys_rst_in <= 1'b0;
			nvm.load(~w, !cp);
			repeat (3) @(posedge clk_in);
		end
	endtask
	initial begin : watchdog
		repeat (3000) @(posedge clk_in);
		errors = errors + 1;
		finish_test;
	end
	initial begin : main
		integer i;
		reg [8:0] c;
		reg [31:0] w, q, e;
		reg cp;
		for (i = 0; i < 6; i = i + 1) begin
			c = CS[i*9 +: 9];
			cp = (i == 1);
			w = {13'h0, c, 5'h1f, i[1:0], i[0], i[1:0]};
			boot(w, cp);
			e = {13'h0, ~c, 10'h0};
			if (c == 9'h0 || e > FB) e = FB;
			chk(wp_limit_out, e);
			chk(wp_enable_out, c != 9'h1ff);
			chk(debug_pair_sel_out, 4'h8 >> i[1:0]);
			chk(scan_port_en_out, i[0]);
			chk(debugger_en_out, !(cp | i[1]));
			bus(1'b0, 4'h0, 32'h0, 4'hf, q);
			chk(q, cp ? w | 32'h3 : w);
			bus(1'b0, 4'h4, 32'h0, 4'hf, q);
			chk(q, {31'h0, i[0]});
			bus(1'b0, 4'hc, 32'h0, 4'hf, q);
			chk(q, {27'h1, !(cp | i[1]), i[0], c != 9'h1ff, c == 9'h0});
		end
		// the decoded scan output follows the control bit one edge later
		bus(1'b1, 4'h4, 32'h0, 4'he, q);
		@(negedge clk_in);
		chk(scan_port_en_out, 1'b1);
		bus(1'b1, 4'h4, 32'h0, 4'h1, q);
		@(negedge clk_in);
		chk(scan_port_en_out, 1'b0);
		bus(1'b0, 4'h4, 32'h0, 4'hf, q);
		chk(q, 32'h0);
		bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf, q);
		bus(1'b0, 4'h8, 32'h0, 4'hf, q);
		chk(q, e);
		bus(1'b0, 4'h2, 32'h0, 4'hf, q);
		chk(q, 32'h0);
		finish_test;
	end
endmodule // tb
